// ==== logic/itwd_pkg.sv ====
// Purpose: constants for the interval timer and watchdog block
// Assumes: classic wishbone, 8-bit registers in the low byte of a word
// Notes: byte address is four times the register index
package itwd_pkg;
   // ------------------------------------------------------------
   // register indices and address width
   // ------------------------------------------------------------
   localparam logic [7:0] ITWD_IDX_CLKCTL = 8'h8b;
   localparam logic [7:0] ITWD_IDX_ICOUNT = 8'h8c;
   localparam logic [7:0] ITWD_IDX_WDMODE = 8'h8d;
   localparam logic [7:0] ITWD_IDX_WDCMP = 8'h8e;
   localparam logic [7:0] ITWD_IDX_IRQSTAT = 8'h90;
   localparam logic [7:0] ITWD_IDX_IRQMASK = 8'h91;
   localparam logic [7:0] ITWD_IDX_STATUS = 8'h92;
   localparam int ITWD_AW = 10;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int ITWD_CC_IRQF = 7;
   localparam int ITWD_CC_CLR = 3;
   localparam int ITWD_WM_EN = 7;
   localparam int ITWD_WM_RSON = 6;
   localparam int ITWD_WM_CLR = 5;
   localparam int ITWD_WM_IRQF = 0;
   localparam int ITWD_EV_IT = 0;
   localparam int ITWD_EV_WD = 1;
   localparam int ITWD_EV_STAB = 2;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [2:0] ITWD_PSEL_RST = 3'h5;
   localparam logic [7:0] ITWD_CMP_RST = 8'hff;
   localparam logic [7:0] ITWD_CNT_RST = 8'h00;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int ITWD_CLK_MHZ = 100;
   localparam int ITWD_TICK_NS = 256000;
   localparam int ITWD_TICK_CYC = ITWD_TICK_NS * ITWD_CLK_MHZ / 1000;
   typedef enum logic [1:0] {
      ITWD_ST_WAIT = 2'h0,
      ITWD_ST_RUN = 2'h1
   } itwd_state_t;
endpackage

// ==== logic/itwd_top.sv ====
// Purpose: interval timer with watchdog counter behind a wishbone slave
// Assumes: inputs synchronous to clk, classic wishbone single cycles
// Notes: the interval count advances once per prescaled tick
//
// Summary of operation
// (R1) eight-bit interval counter always counts up
// (R2) interval counter times oscillator stabilisation waits
// (R3) overflow period sets the interval interrupt flag
// (R4) period select doubles period per code
// (R5) interval clear bit zeroes the counter
// (R6) interval clear bit self-clears after one cycle
// (R7) interval count readable, read-only
// (R8) watchdog advances only on interval overflow
// (R9) watchdog count equal compare raises flag
// (R10) watchdog period equals overflow times compare plus one
// (R11) reset select chooses cpu reset or interrupt
// (R12) response selectable, fixed interval interrupt possible
// (R13) watchdog clear bit zeroes watchdog counter
// (R14) watchdog clear bit self-clears after one cycle
// (R15) shared address: write compare, read count
// (R16) software keeps compare value above one
// (R17) enable bit gates the whole watchdog
// (R18) flags cleared by zero write or acknowledge
// (R19) all state takes defaults on reset
//
// The Wishbone interface to the registers was left to the implementer.
module itwd_top import itwd_pkg::*; #(
   parameter int TICK_CYC = ITWD_TICK_CYC,
   parameter int STAB_CODE = 5
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ITWD_AW-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic stop_exit,
   input wire logic wd_irq_ack,
   output logic osc_stable,
   output logic cpu_reset_req,
   output logic irq
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [31:0] pre_reg, pre_next;
   logic [15:0] icnt_reg, icnt_next;
   logic [2:0] psel_reg, psel_next;
   logic iflag_reg, iflag_next;
   logic iclr_reg, iclr_next;
   logic [7:0] wcnt_reg, wcnt_next;
   logic [7:0] wcmp_reg, wcmp_next;
   logic wen_reg, wen_next;
   logic rson_reg, rson_next;
   logic wclr_reg, wclr_next;
   logic wflag_reg, wflag_next;
   logic [2:0] stat_reg, stat_next;
   logic [2:0] mask_reg, mask_next;
   logic rst_reg, rst_next;
   logic ack_reg, ack_next;
   logic [31:0] dat_reg, dat_next;
   itwd_state_t st_reg, st_next;

   logic tick, ovf, match, stab_done, req, wd_evt;
   logic wr_cc, wr_wm, wr_cmp, wr_mask, rd_stat;
   logic [7:0] wd8;
   logic [15:0] ovf_mask;

   function automatic logic hit(input logic [ITWD_AW-1:0] a,
                                input logic [7:0] idx);
      hit = (a[ITWD_AW-1:2] == idx) && (a[1:0] == 2'h0);
   endfunction

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   assign req = wb_cyc_i && wb_stb_i && !ack_reg;
   assign wd8 = wb_dat_i[7:0];
   assign wr_cc = req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i,
                  ITWD_IDX_CLKCTL);
   assign wr_wm = req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i,
                  ITWD_IDX_WDMODE);
   assign wr_cmp = req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i,
                   ITWD_IDX_WDCMP);
   assign wr_mask = req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i,
                    ITWD_IDX_IRQMASK);
   assign rd_stat = req && !wb_we_i && hit(wb_adr_i, ITWD_IDX_IRQSTAT);

   // ------------------------------------------------------------
   // interval timer
   // ------------------------------------------------------------
   // the low byte is the visible count; upper bits stay zero, the mask ends at bit 7
   // so that code 000 gives two visible-count ticks and 111 gives 256
   assign tick = (pre_reg == 32'(TICK_CYC - 1));
   assign ovf_mask = 16'((17'h2 << psel_reg) - 17'h1); // [R4]
   assign ovf = tick && ((icnt_reg & ovf_mask) == ovf_mask); // [R3]
   assign match = (wcnt_reg == wcmp_reg); // [R9]
   // a clear in flight masks the match that it would otherwise race
   assign wd_evt = wen_reg && ovf && match && !wclr_reg; // [R9] [R17]
   assign stab_done = ovf && (psel_reg == 3'(STAB_CODE));

   always_comb begin
      pre_next = tick ? 32'h0 : pre_reg + 32'h1; // [R1]
      icnt_next = icnt_reg;
      if (iclr_reg) begin
         icnt_next = 16'h0; // [R5]
         pre_next = 32'h0;
      end else if (tick) begin
         icnt_next = ovf ? 16'h0 : icnt_reg + 16'h1; // [R1]
      end
      psel_next = wr_cc ? wd8[2:0] : psel_reg;
      iclr_next = wr_cc && wd8[ITWD_CC_CLR]; // [R6]
      iflag_next = iflag_reg;
      if (wr_cc && !wd8[ITWD_CC_IRQF]) begin
         iflag_next = 1'b0; // [R18]
      end
      if (ovf) begin
         iflag_next = 1'b1; // [R3]
      end
   end

   // ------------------------------------------------------------
   // stabilisation wait after reset or stop exit
   // ------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      case (st_reg)
         ITWD_ST_WAIT: if (stab_done) st_next = ITWD_ST_RUN; // [R2]
         ITWD_ST_RUN: if (stop_exit) st_next = ITWD_ST_WAIT; // [R2]
         default: st_next = ITWD_ST_WAIT;
      endcase
   end
   assign osc_stable = (st_reg == ITWD_ST_RUN);

   // ------------------------------------------------------------
   // watchdog
   // ------------------------------------------------------------
   // compare values 0 and 1 are left to software to avoid [R16]
   always_comb begin
      wcnt_next = wcnt_reg;
      if (wclr_reg || !wen_reg) begin
         wcnt_next = ITWD_CNT_RST; // [R13] [R17]
      end else if (ovf) begin
         // wrap on match gives compare plus one overflows per period
         wcnt_next = match ? 8'h00 : wcnt_reg + 8'h01; // [R8] [R10]
      end
      wcmp_next = wr_cmp ? wd8 : wcmp_reg; // [R15]
      wen_next = wr_wm ? wd8[ITWD_WM_EN] : wen_reg;
      rson_next = wr_wm ? wd8[ITWD_WM_RSON] : rson_reg; // [R12]
      wclr_next = wr_wm && wd8[ITWD_WM_CLR]; // [R14]
      wflag_next = wflag_reg;
      if ((wr_wm && !wd8[ITWD_WM_IRQF]) || wd_irq_ack) begin
         wflag_next = 1'b0; // [R18]
      end
      rst_next = 1'b0;
      if (wd_evt) begin
         if (rson_reg) begin
            rst_next = 1'b1; // [R11]
         end else begin
            wflag_next = 1'b1; // [R11] [R12]
         end
      end
   end
   assign cpu_reset_req = rst_reg;

   // ------------------------------------------------------------
   // interrupt status and mask
   // ------------------------------------------------------------
   always_comb begin
      stat_next = rd_stat ? 3'h0 : stat_reg;
      if (ovf) stat_next[ITWD_EV_IT] = 1'b1;
      if (wd_evt && !rson_reg)
         stat_next[ITWD_EV_WD] = 1'b1;
      if (stab_done && st_reg == ITWD_ST_WAIT)
         stat_next[ITWD_EV_STAB] = 1'b1;
      mask_next = wr_mask ? wd8[2:0] : mask_reg;
   end
   assign irq = |(stat_reg & mask_reg);

   // ------------------------------------------------------------
   // read mux and ack
   // ------------------------------------------------------------
   always_comb begin
      ack_next = req;
      dat_next = 32'h0;
      if (req && !wb_we_i) begin
         if (hit(wb_adr_i, ITWD_IDX_CLKCTL))
            dat_next[7:0] = {iflag_reg, 3'h0, iclr_reg, psel_reg};
         else if (hit(wb_adr_i, ITWD_IDX_ICOUNT))
            dat_next[7:0] = icnt_reg[7:0]; // [R7]
         else if (hit(wb_adr_i, ITWD_IDX_WDMODE))
            dat_next[7:0] = {wen_reg, rson_reg, wclr_reg, 4'h0,
                             wflag_reg};
         else if (hit(wb_adr_i, ITWD_IDX_WDCMP))
            dat_next[7:0] = wcnt_reg; // [R15]
         else if (hit(wb_adr_i, ITWD_IDX_IRQSTAT))
            dat_next[2:0] = stat_reg;
         else if (hit(wb_adr_i, ITWD_IDX_IRQMASK))
            dat_next[2:0] = mask_reg;
         else if (hit(wb_adr_i, ITWD_IDX_STATUS))
            dat_next[0] = osc_stable;
      end
   end
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   // one register process per group keeps each reset list beside
   // the state that it belongs to
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pre_reg <= 32'h0; // [R19]
         icnt_reg <= 16'h0;
         psel_reg <= ITWD_PSEL_RST;
         iflag_reg <= 1'b0;
         iclr_reg <= 1'b0;
      end else begin
         pre_reg <= pre_next;
         icnt_reg <= icnt_next;
         psel_reg <= psel_next;
         iflag_reg <= iflag_next;
         iclr_reg <= iclr_next;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_reg <= ITWD_ST_WAIT; // [R2] [R19]
      end else begin
         st_reg <= st_next;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         wcnt_reg <= ITWD_CNT_RST; // [R19]
         wcmp_reg <= ITWD_CMP_RST;
         wen_reg <= 1'b0;
         rson_reg <= 1'b0;
         wclr_reg <= 1'b0;
         wflag_reg <= 1'b0;
         rst_reg <= 1'b0;
      end else begin
         wcnt_reg <= wcnt_next;
         wcmp_reg <= wcmp_next;
         wen_reg <= wen_next;
         rson_reg <= rson_next;
         wclr_reg <= wclr_next;
         wflag_reg <= wflag_next;
         rst_reg <= rst_next;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         stat_reg <= 3'h0; // [R19]
         mask_reg <= 3'h0;
      end else begin
         stat_reg <= stat_next;
         mask_reg <= mask_next;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ack_reg <= 1'b0; // [R19]
         dat_reg <= 32'h0;
      end else begin
         ack_reg <= ack_next;
         dat_reg <= dat_next;
      end
   end
endmodule // itwd_top

// ==== tb/itwd_properties.sv ====
// Purpose: port-level timing checks for itwd_top
// Assumes: one clock, synchronous active-low reset
// Notes: sees only the top ports, attached by bind
module itwd_properties (
   input wire logic clk,
   input wire logic resetn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic stop_exit,
   input wire logic osc_stable,
   input wire logic cpu_reset_req,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_release;
      !resetn ##1 resetn;
   endsequence
   property p_ack_next;
      s_take |=> wb_ack_o;
   endproperty
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   property p_ack_cause;
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
   endproperty
   property p_dat_hi;
      wb_ack_o |-> wb_dat_o[31:8] == 24'h0;
   endproperty
   property p_rst_pulse;
      cpu_reset_req |=> !cpu_reset_req;
   endproperty
   property p_stop;
      osc_stable && stop_exit |-> ##[1:2] !osc_stable;
   endproperty
   // reset itself is the antecedent, so the default disable is lifted
   property p_reset_idle;
      disable iff (1'b0)
      !resetn |=> !wb_ack_o && !cpu_reset_req && !osc_stable && !irq;
   endproperty
   property p_after_reset;
      disable iff (1'b0) s_release |-> !osc_stable;
   endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("ack not given after request");
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (p_ack_cause)
      else $error("ack without request");
   a_dat_hi: assert property (p_dat_hi)
      else $error("upper read data not zero");
   a_rst_pulse: assert property (p_rst_pulse)
      else $error("cpu reset request too long");
   a_stop: assert property (p_stop)
      else $error("stop exit did not restart wait");
   a_reset_idle: assert property (p_reset_idle)
      else $error("outputs active during reset");
   a_after_reset: assert property (p_after_reset)
      else $error("stable before wait after reset");
endmodule // itwd_properties

bind itwd_top itwd_properties u_prop (.clk(clk), .resetn(resetn),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .stop_exit(stop_exit), .osc_stable(osc_stable),
   .cpu_reset_req(cpu_reset_req), .irq(irq));

// ==== tb/test_itwd_top.sv ====
// Purpose: self-checking bench for itwd_top
// Assumes: TICK_CYC 2, so code 3 overflows every 32 cycles
// Notes: times are compared in ns at a 10 ns clock
module test_itwd_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, resetn = 0, cyc = 0, stb = 0, we = 0;
   logic stop_exit = 0, wd_irq_ack = 0, ack, osc_stable, cpu_reset_req, irq;
   logic [9:0] adr = '0;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat_i = '0, dat_o;
   logic [7:0] q;
   int mismatches = 0, num_checks = 0;
   time t0, t1;
   itwd_top #(.TICK_CYC(2), .STAB_CODE(3)) uut (.clk(clk), .resetn(resetn),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .stop_exit(stop_exit), .wd_irq_ack(wd_irq_ack),
      .osc_stable(osc_stable), .cpu_reset_req(cpu_reset_req), .irq(irq));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   initial begin
      forever #5 clk = ~clk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one classic cycle; trailing idle edge keeps requests apart
   // waits for ack however long it takes; only the watchdog ends a hang
   task wb(input logic w, input logic [9:0] a, input logic [7:0] d);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      dat_i <= {24'h0, d};
      sel <= 4'h1;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = dat_o[7:0];
      chk(dat_o & 32'hffffff00, 32'h0);
      cyc <= 0;
      stb <= 0;
      we <= 0;
      @(posedge clk);
   endtask
   task wait_irq(output time t);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      chk(n < 3000, 1);
      t = $time;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_defaults;
      wb(0, 10'h22c, 0); chk(q, 8'h05);
      wb(0, 10'h234, 0); chk(q, 8'h00);
      wb(0, 10'h238, 0); chk(q, 8'h00);
      wb(1, 10'h3fc, 8'hff);
      wb(0, 10'h3fc, 0); chk(q, 8'h00);
      $display("done defaults");
   endtask
   task t_clear_bit;
      logic [7:0] c1;
      wb(1, 10'h22c, 8'h0b);
      wb(0, 10'h22c, 0); chk(q, 8'h03);
      wb(0, 10'h230, 0); chk(q < 8'h04, 1);
      c1 = q;
      wb(0, 10'h230, 0); chk(q != c1, 1);
      $display("done clear bit");
   endtask
   task t_interval_period;
      wb(1, 10'h244, 8'h01);
      wb(0, 10'h240, 0);
      wait_irq(t0);
      wb(0, 10'h240, 0); chk(q[0], 1);
      wait_irq(t1);
      chk(32'(t1 - t0), 32'd320);
      wb(0, 10'h240, 0);
      wb(0, 10'h22c, 0); chk(q, 8'h83);
      wb(1, 10'h22c, 8'h03);
      wb(0, 10'h22c, 0); chk(q, 8'h03);
      $display("done interval period");
   endtask
   task t_wd_interrupt;
      wb(1, 10'h238, 8'h02);
      wb(1, 10'h234, 8'ha0);
      wb(1, 10'h244, 8'h02);
      wb(0, 10'h240, 0);
      wait_irq(t0);
      wb(0, 10'h240, 0); chk(q[1], 1);
      wait_irq(t1);
      chk(32'(t1 - t0), 32'd960);
      wb(0, 10'h234, 0); chk(q, 8'h81);
      wd_irq_ack <= 1;
      @(posedge clk);
      wd_irq_ack <= 0;
      wb(0, 10'h234, 0); chk(q, 8'h80);
      $display("done watchdog interrupt");
   endtask
   task t_wd_reset;
      int n;
      t0 = $time;
      wb(1, 10'h22c, 8'h0b);
      wb(1, 10'h234, 8'he0);
      wb(0, 10'h238, 0); chk(q, 8'h00);
      n = 0;
      while (cpu_reset_req !== 1'b1 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      t1 = $time - t0;
      chk(t1 >= 900 && t1 <= 1000, 1);
      $display("done watchdog reset");
   endtask
   task t_disabled;
      wb(1, 10'h234, 8'h20);
      repeat (100) @(posedge clk);
      wb(0, 10'h238, 0); chk(q, 8'h00);
      $display("done disabled");
   endtask
   task t_stop;
      int n;
      chk(osc_stable, 1);
      wb(0, 10'h248, 0); chk(q, 8'h01);
      stop_exit <= 1;
      @(posedge clk);
      stop_exit <= 0;
      repeat (3) @(posedge clk);
      chk(osc_stable, 0);
      n = 0;
      while (osc_stable !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      chk(n < 200, 1);
      wb(0, 10'h240, 0); chk(q[2], 1);
      $display("done stop exit");
   endtask
   // ------------------------------------------------------------
   // sequence and verdict
   // ------------------------------------------------------------
   task give_verdict;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #100000;
      mismatches++;
      give_verdict;
   end
   initial begin
      repeat (8) @(posedge clk);
      resetn <= 1;
      @(posedge clk);
      t_defaults;
      t_clear_bit;
      t_interval_period;
      t_wd_interrupt;
      t_wd_reset;
      t_disabled;
      t_stop;
      give_verdict;
   end
endmodule // test_itwd_top
